// >>> common/lcmf_pkg.sv
// Shared constants, types and decode functions for the multiplexed display frame controller
package lcmf_pkg;
   localparam int NUM_BP = 4;
   localparam int BYTES_PER_BP = 6;
   localparam int NUM_BYTES = 24;
   localparam int NUM_SEG = 45;
   localparam int SEG_SKIP = 3;
   localparam int GROUP_W = 48;
   // Register indices; byte address is four times the index
   localparam logic [7:0] MODE_IDX = 8'hDC;
   localparam logic [7:0] STATUS_IDX = 8'hDE;
   localparam logic [7:0] RAM_FIRST_IDX = 8'hE0;
   localparam logic [7:0] RAM_LAST_IDX = 8'hF7;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // Output level codes: the two bias codes merge to half level when the bias pins are shorted
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_THIRD = 2'h1;
   localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
   localparam logic [1:0] LVL_FULL = 2'h3;

   typedef struct packed {
      logic [1:0] mux_sel;
      logic [2:0] osc_sel;
      logic [2:0] frame_sel;
   } lcmf_mode_t;

   typedef struct packed {
      logic [NUM_SEG-1:0][1:0] seg;
      logic [NUM_BP-1:0][1:0] bp;
   } lcmf_drive_t;

   typedef struct packed {
      logic fail_s1;
      logic fail_s2;
      lcmf_mode_t mode;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic [1:0] slot;
      logic pol;
      logic bias_en;
      lcmf_drive_t drive;
   } lcmf_state_t;

   function automatic logic [8:0] osc_factor(input logic [2:0] code);
      case (code)
         3'h3: osc_factor = 9'h020;
         3'h4: osc_factor = 9'h040;
         3'h5: osc_factor = 9'h080;
         3'h6: osc_factor = 9'h100;
         default: osc_factor = 9'h000;
      endcase
   endfunction : osc_factor

   function automatic logic [9:0] frame_factor(input logic [2:0] code);
      case (code)
         3'h0: frame_factor = 10'h200;
         3'h1: frame_factor = 10'h182;
         3'h2: frame_factor = 10'h100;
         3'h3: frame_factor = 10'h0C0;
         3'h4: frame_factor = 10'h080;
         3'h5: frame_factor = 10'h060;
         3'h6: frame_factor = 10'h040;
         default: frame_factor = 10'h000;
      endcase
   endfunction : frame_factor

   function automatic logic [2:0] active_bp(input logic [1:0] mux);
      case (mux)
         2'h0: active_bp = 3'h4;
         2'h1: active_bp = 3'h1;
         2'h2: active_bp = 3'h2;
         default: active_bp = 3'h3;
      endcase
   endfunction : active_bp

   function automatic logic is_ram(input logic [7:0] idx);
      is_ram = (idx >= RAM_FIRST_IDX) && (idx <= RAM_LAST_IDX);
   endfunction : is_ram
endpackage : lcmf_pkg

// >>> verilog/lcmf_clk_div.sv
// Enable-pulse divider: one tick every factor_i steps
`timescale 1ns/1ps
`default_nettype none
module lcmf_clk_div #(
   parameter int W = 10
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic clear_i,
   input wire logic step_i,
   input wire logic [W-1:0] factor_i,
   // Output
   output logic tick_o
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic last;

   assign last = (cnt_r == factor_i - W'(1)) || (cnt_r >= factor_i);
   assign tick_o = step_i && !clear_i && last;

   always_comb begin
      cnt_nxt = cnt_r;
      if (clear_i) begin
         cnt_nxt = '0;
      end else if (step_i) begin
         cnt_nxt = last ? '0 : cnt_r + W'(1);
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : lcmf_clk_div
`default_nettype wire

// >>> verilog/lcmf_disp_ram.sv
// Display RAM: byte port for software, one backplane group for the scanner
`timescale 1ns/1ps
`default_nettype none
module lcmf_disp_ram (
   // Clock
   input wire logic core_clk_i,
   // Software port
   input wire logic we_i,
   input wire logic [4:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [4:0] raddr_i,
   output logic [7:0] rdata_o,
   // Scanner port
   input wire logic [1:0] slot_i,
   output logic [lcmf_pkg::GROUP_W-1:0] group_o
);
   logic [7:0] mem [0:lcmf_pkg::NUM_BYTES-1];
   logic [4:0] base;

   // No reset: contents stay arbitrary until software writes them
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[raddr_i];
   assign base = 5'(slot_i) * 5'(lcmf_pkg::BYTES_PER_BP);

   always_comb begin
      for (int b = 0; b < lcmf_pkg::BYTES_PER_BP; b++) begin
         group_o[b*8 +: 8] = mem[base + 5'(b)];
      end
   end
endmodule : lcmf_disp_ram
`default_nettype wire

// >>> verilog/lcmf_frame_ctrl.sv
// Multiplexed display frame controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module lcmf_frame_ctrl (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Core power state and clock supervisor
   input wire logic stop_i,
   input wire logic osc_fail_i,
   // Panel drive
   output lcmf_pkg::lcmf_drive_t lcd_drive_o,
   output logic bias_enable_o
);
   lcmf_pkg::lcmf_state_t st_r;
   lcmf_pkg::lcmf_state_t st_nxt;

   logic addr_ok;
   logic [7:0] idx;
   logic [7:0] rd_byte;
   logic [7:0] ram_rd;
   logic [lcmf_pkg::GROUP_W-1:0] group;
   logic [2:0] nbp;
   logic [8:0] osc_div;
   logic [9:0] frm_div;
   logic run;
   logic ref_tick;
   logic base_tick;
   logic ram_we;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign idx = haddr_i[9:2];
   assign addr_ok = hsel_i && htrans_i[1] && hready_i && (haddr_i[31:10] == 22'h00_0000)
                    && (haddr_i[1:0] == 2'h0);
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = st_r.rdata;
   assign ram_we = st_r.wr_pend && lcmf_pkg::is_ram(st_r.wr_idx);

   always_comb begin
      rd_byte = 8'h00;
      if (idx == lcmf_pkg::MODE_IDX) begin
         rd_byte = st_r.mode;
      end else if (idx == lcmf_pkg::STATUS_IDX) begin
         rd_byte = {3'h0, st_r.fail_s2, st_r.slot, st_r.pol, run};
      end else if (lcmf_pkg::is_ram(idx)) begin
         // Forward a write still in its data phase to a back-to-back read
         rd_byte = (st_r.wr_pend && st_r.wr_idx == idx) ? hwdata_i[7:0] : ram_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock chain

   assign osc_div = lcmf_pkg::osc_factor(st_r.mode.osc_sel);
   assign frm_div = lcmf_pkg::frame_factor(st_r.mode.frame_sel);
   assign nbp = lcmf_pkg::active_bp(st_r.mode.mux_sel);
   // Reserved frame code is treated like a disabled clock
   assign run = (osc_div != 9'h000) && (frm_div != 10'h000) && !stop_i && !st_r.fail_s2;

   lcmf_clk_div #(.W(9)) u_ref_div (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(!run),
      .step_i(1'b1),
      .factor_i(osc_div),
      .tick_o(ref_tick)
   );

   lcmf_clk_div #(.W(10)) u_base_div (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(!run),
      .step_i(ref_tick),
      .factor_i(frm_div),
      .tick_o(base_tick)
   );

   lcmf_disp_ram u_ram (
      .core_clk_i(core_clk_i),
      .we_i(ram_we),
      .waddr_i(5'(st_r.wr_idx - lcmf_pkg::RAM_FIRST_IDX)),
      .wdata_i(hwdata_i[7:0]),
      .raddr_i(5'(idx - lcmf_pkg::RAM_FIRST_IDX)),
      .rdata_o(ram_rd),
      .slot_i(st_r.slot),
      .group_o(group)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;
      st_nxt.fail_s1 = osc_fail_i;
      st_nxt.fail_s2 = st_r.fail_s1;
      st_nxt.wr_pend = addr_ok && hwrite_i;
      st_nxt.wr_idx = idx;
      if (st_r.wr_pend && st_r.wr_idx == lcmf_pkg::MODE_IDX) begin
         st_nxt.mode = hwdata_i[7:0];
      end
      if (addr_ok && !hwrite_i) begin
         st_nxt.rdata = {24'h00_0000, rd_byte};
      end

      // One base period per slot, so a frame lasts nbp base periods
      if (!run) begin
         st_nxt.slot = 2'h0;
         st_nxt.pol = 1'b0;
      end else if ({1'b0, st_r.slot} >= nbp) begin
         st_nxt.slot = 2'h0;
      end else if (base_tick) begin
         if ({1'b0, st_r.slot} == nbp - 3'h1) begin
            st_nxt.slot = 2'h0;
            st_nxt.pol = !st_r.pol;
         end else begin
            st_nxt.slot = st_r.slot + 2'h1;
         end
      end

      st_nxt.bias_en = run;
      for (int k = 0; k < lcmf_pkg::NUM_BP; k++) begin
         if (!run || 3'(k) >= nbp) begin
            st_nxt.drive.bp[k] = lcmf_pkg::LVL_GND;
         end else if (2'(k) == st_r.slot) begin
            st_nxt.drive.bp[k] = st_r.pol ? lcmf_pkg::LVL_GND : lcmf_pkg::LVL_FULL;
         end else begin
            st_nxt.drive.bp[k] = st_r.pol ? lcmf_pkg::LVL_TWO_THIRD : lcmf_pkg::LVL_THIRD;
         end
      end
      for (int s = 0; s < lcmf_pkg::NUM_SEG; s++) begin
         if (!run) begin
            st_nxt.drive.seg[s] = lcmf_pkg::LVL_GND;
         end else if (group[lcmf_pkg::SEG_SKIP + s]) begin
            st_nxt.drive.seg[s] = st_r.pol ? lcmf_pkg::LVL_FULL : lcmf_pkg::LVL_GND;
         end else begin
            st_nxt.drive.seg[s] = st_r.pol ? lcmf_pkg::LVL_THIRD : lcmf_pkg::LVL_TWO_THIRD;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
         st_r.mode <= lcmf_pkg::MODE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lcd_drive_o = st_r.drive;
   assign bias_enable_o = st_r.bias_en;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   logic [9:0] slot_len;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         slot_len <= 10'h000;
      end else if (!run || base_tick) begin
         slot_len <= 10'h000;
      end else if (ref_tick) begin
         slot_len <= slot_len + 10'h001;
      end
   end

   a_stop_grounds: assert property (stop_i |=> (lcd_drive_o == '0) && !bias_enable_o)
      else $error("outputs not grounded after stop");
   a_fail_grounds: assert property (osc_fail_i [*3] |=> (lcd_drive_o == '0))
      else $error("outputs not grounded after oscillator failure");
   a_bad_osc_off: assert property ((st_r.mode.osc_sel inside {3'h0, 3'h1, 3'h2, 3'h7}) |=> !bias_enable_o)
      else $error("display running with invalid oscillator code");
   a_bias_tracks: assert property (bias_enable_o == $past(run))
      else $error("bias enable does not follow run state");
   a_mode_write: assert property (st_r.wr_pend && st_r.wr_idx == lcmf_pkg::MODE_IDX
                                  |=> st_r.mode == $past(hwdata_i[7:0]))
      else $error("mode register write lost");
   a_slot_wrap: assert property (run && base_tick && {1'b0, st_r.slot} == nbp - 3'h1
                                 |=> st_r.slot == 2'h0 && st_r.pol != $past(st_r.pol))
      else $error("slot did not wrap at frame end");
   a_slot_len: assert property (slot_len <= frm_div)
      else $error("slot longer than base period");
   a_unused_bp: assert property (st_r.mode.mux_sel == 2'h1 && $past(st_r.mode.mux_sel) == 2'h1
                                 |-> lcd_drive_o.bp[1] == lcmf_pkg::LVL_GND)
      else $error("unused backplane driven in single ratio");
   a_ref_period: assert property (run && ref_tick && $past(run, 1) |-> ##1 !ref_tick [*3])
      else $error("reference tick too frequent");
   a_seg_on: assert property (run && $past(run) && st_r.pol && group[lcmf_pkg::SEG_SKIP] && !ram_we
                              |=> lcd_drive_o.seg[0] == lcmf_pkg::LVL_FULL)
      else $error("lit segment not driven");

   a_bias_idle: assert property (!run |=> !bias_enable_o)
      else $error("bias left on while display off");

   a_sel_full: assert property (run && st_r.slot == 2'h0 && !st_r.pol
                                |=> lcd_drive_o.bp[0] == lcmf_pkg::LVL_FULL)
      else $error("selected backplane not at full level");

   a_unsel_third: assert property (run && st_r.slot != 2'h0 && !st_r.pol
                                   |=> lcd_drive_o.bp[0] == lcmf_pkg::LVL_THIRD)
      else $error("unselected backplane not at bias level");

   a_seg_off: assert property (run && !group[lcmf_pkg::SEG_SKIP] && !st_r.pol
                               |=> lcd_drive_o.seg[0] == lcmf_pkg::LVL_TWO_THIRD)
      else $error("dark segment driven wrongly");

   a_no_tick_off: assert property (!run |-> !ref_tick && !base_tick)
      else $error("divider ticking while display off");

   a_rd_mode: assert property (addr_ok && !hwrite_i && idx == lcmf_pkg::MODE_IDX
                               |=> hrdata_o == {24'h00_0000, $past(st_r.mode)})
      else $error("mode read data wrong");

   a_rd_upper: assert property (hrdata_o[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");

   a_fail_bias: assert property (st_r.fail_s2 |=> !bias_enable_o)
      else $error("bias on after synced oscillator failure");

   a_pol_hold: assert property (run && !base_tick |=> st_r.pol == $past(st_r.pol))
      else $error("polarity changed inside a frame");

   a_unused_bp4: assert property (run && nbp != 3'h4 |=> lcd_drive_o.bp[3] == lcmf_pkg::LVL_GND)
      else $error("fourth backplane driven while unused");

   a_base_on_ref: assert property (base_tick |-> ref_tick)
      else $error("base tick without reference tick");

   a_idle_slot: assert property (!run |=> st_r.slot == 2'h0 && !st_r.pol)
      else $error("scan state not cleared while off");

   c_half_ratio: cover property (run && st_r.mode.mux_sel == 2'h2 && base_tick);

   c_full_frame: cover property (run && base_tick && st_r.slot == 2'h3);
   c_single_mux: cover property (run && st_r.mode.mux_sel == 2'h1 && base_tick);
   c_stop_run: cover property (bias_enable_o ##1 stop_i);
   c_ram_fwd: cover property (st_r.wr_pend && addr_ok && !hwrite_i && idx == st_r.wr_idx);
endmodule : lcmf_frame_ctrl
`default_nettype wire

// >>> bench/lcmf_panel_model.sv
// Behavioural display glass seen by the frame controller
`timescale 1ns/1ps
`default_nettype none
module lcmf_panel_model (
   // Drive from the controller
   input wire lcmf_pkg::lcmf_drive_t drive_i,
   input wire logic bias_en_i,
   // Observed glass state
   output logic [lcmf_pkg::NUM_BP-1:0][lcmf_pkg::NUM_SEG-1:0] lit_o,
   output logic stray_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // An element lights only under the full supply difference.
   // Any level left on a line while bias is off is a stray bias.
   always_comb begin
      stray_o = 1'b0;
      for (int b = 0; b < lcmf_pkg::NUM_BP; b++) begin
         for (int s = 0; s < lcmf_pkg::NUM_SEG; s++) begin
            lit_o[b][s] = (drive_i.bp[b] == 2'h3 && drive_i.seg[s] == 2'h0) ||
                          (drive_i.bp[b] == 2'h0 && drive_i.seg[s] == 2'h3);
         end
         if (!bias_en_i && drive_i.bp[b] != 2'h0) begin
            stray_o = 1'b1;
         end
      end
      if (!bias_en_i && drive_i.seg != '0) begin
         stray_o = 1'b1;
      end
   end
endmodule : lcmf_panel_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the display frame controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk_i, reset_n_i, hsel_i, hwrite_i, stop_i, osc_fail_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic hreadyout_o, hresp_o, bias_enable_o, stray;
   lcmf_pkg::lcmf_drive_t lcd_drive_o;
   logic [lcmf_pkg::NUM_BP-1:0][lcmf_pkg::NUM_SEG-1:0] lit;
   logic [7:0] bad [5] = '{8'h5F, 8'h46, 8'h4E, 8'h56, 8'h7E};
   int err_count, samples_checked, n;

   lcmf_frame_ctrl i_lcmf_frame_ctrl (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
      .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .stop_i(stop_i), .osc_fail_i(osc_fail_i), .lcd_drive_o(lcd_drive_o), .bias_enable_o(bias_enable_o));
   lcmf_panel_model i_lcmf_panel_model (.drive_i(lcd_drive_o), .bias_en_i(bias_enable_o), .lit_o(lit),
      .stray_o(stray));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   // One single word transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge core_clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {22'h0, idx, 2'b00};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      @(posedge core_clk_i);
      while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(posedge core_clk_i);
      while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
      rd = hrdata_o;
   endtask : bus

   task automatic wait_cyc(input int c);
      repeat (c) @(posedge core_clk_i);
      #1;
   endtask : wait_cyc

   task automatic setm(input logic [7:0] m);
      bus(1'b1, lcmf_pkg::MODE_IDX, {24'h0, m});
   endtask : setm

   // Length of one backplane-1 phase in 1/1 ratio
   task automatic meas(input logic [7:0] m, input int exp);
      logic [1:0] v;
      int c;
      setm(8'h00);
      setm(m);
      wait_cyc(1);
      v = lcd_drive_o.bp[0];
      while (lcd_drive_o.bp[0] === v) wait_cyc(1);
      v = lcd_drive_o.bp[0];
      c = 0;
      while (lcd_drive_o.bp[0] === v) begin
         wait_cyc(1);
         c++;
      end
      chk(c, exp, "slot length");
   endtask : meas

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   initial begin
      repeat (90000) @(posedge core_clk_i);
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n_i = 1'b0;
      hsel_i = 1'b0;
      haddr_i = 32'h0000_0000;
      htrans_i = 2'h0;
      hwrite_i = 1'b0;
      hsize_i = 3'h2;
      hwdata_i = 32'h0000_0000;
      stop_i = 1'b0;
      osc_fail_i = 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      wait_cyc(1);
      chk(lcd_drive_o, 0, "drive after reset");
      chk(bias_enable_o, 0, "bias after reset");
      bus(1'b0, lcmf_pkg::MODE_IDX, 0);
      chk(rd, 32'h0000_0000, "mode reset");
      bus(1'b0, lcmf_pkg::STATUS_IDX, 0);
      chk(rd, 32'h0000_0000, "status idle");
      setm(8'hA5);
      bus(1'b0, lcmf_pkg::MODE_IDX, 0);
      chk(rd, 32'h0000_00A5, "mode readback");
      chk(hresp_o, 0, "response");
      bus(1'b0, 8'h10, 0);
      chk(rd, 32'h0000_0000, "unmapped read");
      for (int i = 0; i < 24; i++) bus(1'b1, lcmf_pkg::RAM_FIRST_IDX + 8'(i), 0);
      bus(1'b1, 8'hE0, 32'h0000_0008);
      bus(1'b1, 8'hE6, 32'h0000_0010);
      bus(1'b1, 8'hF7, 32'h0000_00FF);
      bus(1'b0, 8'hE6, 0);
      chk(rd, 32'h0000_0010, "ram readback");
      for (int m = 0; m < 4; m++) begin
         setm(8'h00);
         setm({2'(m), 6'b011_110});
         wait_cyc(100);
         n = (m == 0) ? 4 : m;
         chk(bias_enable_o, 1, "bias running");
         for (int b = 0; b < 4; b++) chk(lcd_drive_o.bp[b], b == 0 ? 3 : (b < n ? 1 : 0), "bp level");
         chk(lcd_drive_o.seg[0], 0, "seg4 on");
         chk(lcd_drive_o.seg[1], 2, "seg5 off");
         chk(lit[0][0], 1, "glass lit");
         if (m == 1) begin
            chk(lcd_drive_o.seg[44], 2, "unused byte ignored");
            wait_cyc(2048);
            chk({lcd_drive_o.bp[0], lcd_drive_o.seg[0], lcd_drive_o.seg[1]}, 6'h0D, "next frame");
         end
         if (m == 2) begin
            wait_cyc(2048);
            chk({lcd_drive_o.bp[0], lcd_drive_o.bp[1], lcd_drive_o.seg[1]}, 6'h1C, "second slot");
            bus(1'b0, lcmf_pkg::STATUS_IDX, 0);
            chk(rd, 32'h0000_0005, "status second slot");
         end
      end
      meas(8'h5E, 2048);
      meas(8'h5D, 3072);
      meas(8'h59, 12352);
      meas(8'h66, 4096);
      meas(8'h6E, 8192);
      for (int i = 0; i < 5; i++) begin
         setm(8'h5E);
         setm(bad[i]);
         wait_cyc(5);
         chk(lcd_drive_o, 0, "refused code grounded");
         chk(bias_enable_o, 0, "refused code bias");
      end
      setm(8'h5E);
      wait_cyc(10);
      stop_i <= 1'b1;
      wait_cyc(2);
      chk(lcd_drive_o, 0, "stop grounded");
      chk(stray, 0, "stop stray bias");
      stop_i <= 1'b0;
      wait_cyc(50);
      chk(bias_enable_o, 1, "resume after stop");
      osc_fail_i <= 1'b1;
      wait_cyc(4);
      chk(lcd_drive_o, 0, "fail grounded");
      osc_fail_i <= 1'b0;
      wait_cyc(2);
      close_out();
   end
endmodule : tb
`default_nettype wire
